// File: design/crs_pkg.sv
// Purpose: Shared constants and carrier types of the CPU register set
// Assumes: One 20 MHz clock, active-low asynchronous reset
// Notes: System registers are selected by a 5-bit number
package crs_pkg;
	localparam int CLK_MHZ = 20;
	localparam int CLK_PERIOD_NS = 1000 / CLK_MHZ;
	localparam int INSTR_TIME_NS = 50;
	localparam int INSTR_CYCLES =
		(INSTR_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int PIPE_STAGES = 5;
	localparam int XLEN = 32;
	localparam int GPR_NUM = 32;
	localparam int PC_W = 24;
	localparam int PHYS_W = 22;
	localparam int PSW_W = 8;
	localparam int CODE_W = 16;
	localparam int CAUSE_NMI_LSB = 16;

	localparam logic [4:0] SR_EXC_PC = 5'h00;
	localparam logic [4:0] SR_EXC_ST = 5'h01;
	localparam logic [4:0] SR_NMI_PC = 5'h02;
	localparam logic [4:0] SR_NMI_ST = 5'h03;
	localparam logic [4:0] SR_CAUSE = 5'h04;
	localparam logic [4:0] SR_PSW = 5'h05;

	localparam int PSW_Z = 0;
	localparam int PSW_S = 1;
	localparam int PSW_OV = 2;
	localparam int PSW_CY = 3;
	localparam int PSW_SAT = 4;
	localparam int PSW_ID = 5;
	localparam int PSW_EXC = 6;
	localparam int PSW_NP = 7;

	localparam logic [PC_W-1:0] PC_RST = 24'h000000;
	localparam logic [PSW_W-1:0] PSW_RST = 8'h00;
	localparam logic [XLEN-1:0] SAVE_RST = 32'h00000000;
	localparam logic [XLEN-1:0] CAUSE_RST = 32'h00000000;

	typedef enum logic [1:0] {SH_LEFT, SH_RIGHT, SH_ARITH} crs_shop_t;
	typedef enum logic [1:0] {BIT_SET, BIT_CLR, BIT_NOT, BIT_TST} crs_bitop_t;

	typedef struct packed {
		logic go;
		crs_shop_t op;
		logic [XLEN-1:0] data;
		logic [4:0] amt;
	} crs_sh_req_t;

	typedef struct packed {
		logic go;
		crs_bitop_t op;
		logic [7:0] octet;
		logic [2:0] pos;
	} crs_bit_req_t;

	typedef struct packed {
		logic we;
		logic [4:0] idx;
		logic [XLEN-1:0] data;
	} crs_gpr_wr_t;

	typedef struct packed {
		logic we;
		logic re;
		logic [4:0] idx;
		logic [XLEN-1:0] wdata;
	} crs_sr_req_t;

	typedef struct packed {
		logic exc;
		logic [CODE_W-1:0] exc_code;
		logic nmi;
		logic [CODE_W-1:0] nmi_code;
		logic reti;
	} crs_evt_t;

	typedef struct packed {
		logic we;
		logic z;
		logic s;
		logic ov;
		logic cy;
		logic saturation_flag;
	} crs_flags_t;

	typedef struct packed {
		logic add;
		logic [PC_W-1:0] offset;
		logic load;
		logic [PC_W-1:0] target;
	} crs_pc_req_t;
endpackage : crs_pkg

// File: design/crs_gpr_file.sv
// Purpose: Thirty-two general-purpose registers, two reads, one write
// Assumes: Reads are combinational, the caller registers them
// Notes: Register zero has no storage
module crs_gpr_file
(
	// Clock and reset
	input wire logic clk_i,
	input wire logic nrst_i,
	// Write port
	input wire crs_pkg::crs_gpr_wr_t wr_i,
	// Read ports
	input wire logic [4:0] rd_a_idx_i,
	input wire logic [4:0] rd_b_idx_i,
	output logic [crs_pkg::XLEN-1:0] rd_a_o,
	output logic [crs_pkg::XLEN-1:0] rd_b_o
);
	typedef struct packed {
		logic [crs_pkg::GPR_NUM-1:1][crs_pkg::XLEN-1:0] r;
	} crs_gpr_st_t;

	crs_gpr_st_t q;
	crs_gpr_st_t d;

	function automatic logic [crs_pkg::XLEN-1:0] gpr_sel(
		input crs_gpr_st_t s,
		input logic [4:0] idx
	);
		// Register zero always reads as zero
		if (idx == 5'h00)
			gpr_sel = 32'h00000000;
		else
			gpr_sel = s.r[idx];
	endfunction : gpr_sel

	always_comb
	begin
		d = q;
		// Writes to register zero fall through unstored
		for (int i = 1; i < crs_pkg::GPR_NUM; i++)
		begin
			if (wr_i.we && wr_i.idx == 5'(i))
				d.r[i] = wr_i.data;
		end
	end

	always_ff @(posedge clk_i or negedge nrst_i)
	begin
		if (!nrst_i)
			q <= '0;
		else
			q <= d;
	end

	assign rd_a_o = gpr_sel(q, rd_a_idx_i);
	assign rd_b_o = gpr_sel(q, rd_b_idx_i);
endmodule : crs_gpr_file

// File: design/crs_shift_bit.sv
// Purpose: One-cycle barrel shifter and single-bit manipulation unit
// Assumes: Purely combinational, results registered by the caller
// Notes: Zero output is the inverse of the addressed bit before the op
module crs_shift_bit
(
	// Requests
	input wire crs_pkg::crs_sh_req_t sh_req_i,
	input wire crs_pkg::crs_bit_req_t bit_req_i,
	// Results
	output logic [crs_pkg::XLEN-1:0] sh_res_o,
	output logic [7:0] bit_res_o,
	output logic bit_zero_o
);
	logic [7:0] mask;

	always_comb
	begin
		mask = 8'h01 << bit_req_i.pos;
		// Full-width shift in one pass
		case (sh_req_i.op)
			crs_pkg::SH_LEFT: sh_res_o = sh_req_i.data << sh_req_i.amt;
			crs_pkg::SH_RIGHT: sh_res_o = sh_req_i.data >> sh_req_i.amt;
			crs_pkg::SH_ARITH:
				sh_res_o = $signed(sh_req_i.data) >>> sh_req_i.amt;
			default: sh_res_o = sh_req_i.data;
		endcase
		// Set, clear, invert and test of one bit
		case (bit_req_i.op)
			crs_pkg::BIT_SET: bit_res_o = bit_req_i.octet | mask;
			crs_pkg::BIT_CLR: bit_res_o = bit_req_i.octet & ~mask;
			crs_pkg::BIT_NOT: bit_res_o = bit_req_i.octet ^ mask;
			crs_pkg::BIT_TST: bit_res_o = bit_req_i.octet;
			default: bit_res_o = bit_req_i.octet;
		endcase
		bit_zero_o = ~|(bit_req_i.octet & mask);
	end
endmodule : crs_shift_bit

// File: design/crs_regs.sv
// Purpose: CPU register set with program counter and system registers
// Assumes: Pipeline control drives requests synchronous to clk_i
// Notes: All outputs registered; reads show the state before the edge
module crs_regs
(
	// Clock and reset
	input wire logic clk_i,
	input wire logic nrst_i,
	// Pipeline and program counter control
	input wire logic issue_i,
	input wire crs_pkg::crs_pc_req_t pc_req_i,
	output logic retire_o,
	output logic [crs_pkg::XLEN-1:0] pc_o,
	output logic pc_unimpl_o,
	// General registers
	input wire crs_pkg::crs_gpr_wr_t gpr_wr_i,
	input wire logic [4:0] rd_a_idx_i,
	input wire logic [4:0] rd_b_idx_i,
	output logic [crs_pkg::XLEN-1:0] rd_a_o,
	output logic [crs_pkg::XLEN-1:0] rd_b_o,
	// Shifter and bit unit
	input wire crs_pkg::crs_sh_req_t sh_req_i,
	input wire crs_pkg::crs_bit_req_t bit_req_i,
	output logic [crs_pkg::XLEN-1:0] sh_res_o,
	output logic [7:0] bit_res_o,
	output logic bit_zero_o,
	// System registers, events and flags
	input wire crs_pkg::crs_sr_req_t sr_req_i,
	input wire crs_pkg::crs_evt_t evt_i,
	input wire crs_pkg::crs_flags_t flags_i,
	output logic [crs_pkg::XLEN-1:0] sr_rdata_o,
	output logic [crs_pkg::XLEN-1:0] psw_o
);
	typedef struct packed {
		logic [crs_pkg::PIPE_STAGES-1:0] pipe;
		logic [crs_pkg::PC_W-1:0] pc;
		logic pc_unimpl;
		logic [crs_pkg::XLEN-1:0] exc_pc;
		logic [crs_pkg::XLEN-1:0] exc_st;
		logic [crs_pkg::XLEN-1:0] nmi_pc;
		logic [crs_pkg::XLEN-1:0] nmi_st;
		logic [crs_pkg::XLEN-1:0] cause;
		logic [crs_pkg::PSW_W-1:0] program_status_word;
		logic [crs_pkg::XLEN-1:0] rd_a;
		logic [crs_pkg::XLEN-1:0] rd_b;
		logic [crs_pkg::XLEN-1:0] sh_res;
		logic [7:0] bit_res;
		logic bit_zero;
		logic [crs_pkg::XLEN-1:0] sr_rdata;
	} crs_top_st_t;

	localparam crs_top_st_t ST_RST = '{
		pipe: '0,
		pc: crs_pkg::PC_RST,
		pc_unimpl: 1'b0,
		exc_pc: crs_pkg::SAVE_RST,
		exc_st: crs_pkg::SAVE_RST,
		nmi_pc: crs_pkg::SAVE_RST,
		nmi_st: crs_pkg::SAVE_RST,
		cause: crs_pkg::CAUSE_RST,
		program_status_word: crs_pkg::PSW_RST,
		rd_a: '0,
		rd_b: '0,
		sh_res: '0,
		bit_res: '0,
		bit_zero: 1'b0,
		sr_rdata: '0
	};

	crs_top_st_t q;
	crs_top_st_t d;
	logic [crs_pkg::XLEN-1:0] gpr_a;
	logic [crs_pkg::XLEN-1:0] gpr_b;
	logic [crs_pkg::XLEN-1:0] sh_res;
	logic [7:0] bit_res;
	logic bit_zero;

	crs_gpr_file u_gpr
	(
		.clk_i(clk_i),
		.nrst_i(nrst_i),
		.wr_i(gpr_wr_i),
		.rd_a_idx_i(rd_a_idx_i),
		.rd_b_idx_i(rd_b_idx_i),
		.rd_a_o(gpr_a),
		.rd_b_o(gpr_b)
	);

	crs_shift_bit u_alu
	(
		.sh_req_i(sh_req_i),
		.bit_req_i(bit_req_i),
		.sh_res_o(sh_res),
		.bit_res_o(bit_res),
		.bit_zero_o(bit_zero)
	);

	function automatic logic [crs_pkg::XLEN-1:0] sr_read(
		input crs_top_st_t s,
		input logic [4:0] idx
	);
		// Numbers 6 to 31 are reserved and read zero
		case (idx)
			crs_pkg::SR_EXC_PC: sr_read = s.exc_pc;
			crs_pkg::SR_EXC_ST: sr_read = s.exc_st;
			crs_pkg::SR_NMI_PC: sr_read = s.nmi_pc;
			crs_pkg::SR_NMI_ST: sr_read = s.nmi_st;
			crs_pkg::SR_CAUSE: sr_read = s.cause;
			crs_pkg::SR_PSW: sr_read = {24'h000000, s.program_status_word};
			default: sr_read = 32'h00000000;
		endcase
	endfunction : sr_read

	always_comb
	begin
		d = q;
		// One instruction enters per clock, each leaves five later
		d.pipe = {q.pipe[crs_pkg::PIPE_STAGES-2:0], issue_i};
		// 24-bit sum: carry out of bit 23 is lost
		if (pc_req_i.add)
			d.pc = q.pc + pc_req_i.offset;
		if (pc_req_i.load)
			d.pc = pc_req_i.target;
		d.rd_a = gpr_a;
		d.rd_b = gpr_b;
		if (sh_req_i.go)
			d.sh_res = sh_res;
		if (bit_req_i.go)
		begin
			d.bit_res = bit_res;
			d.bit_zero = bit_zero;
		end
		if (sr_req_i.re)
			d.sr_rdata = sr_read(q, sr_req_i.idx);
		// Load into the selected system register by number
		if (sr_req_i.we)
		begin
			case (sr_req_i.idx)
				crs_pkg::SR_EXC_PC: d.exc_pc = sr_req_i.wdata;
				crs_pkg::SR_EXC_ST: d.exc_st = sr_req_i.wdata;
				crs_pkg::SR_NMI_PC: d.nmi_pc = sr_req_i.wdata;
				crs_pkg::SR_NMI_ST: d.nmi_st = sr_req_i.wdata;
				crs_pkg::SR_CAUSE: d.cause = sr_req_i.wdata;
				crs_pkg::SR_PSW: d.program_status_word = sr_req_i.wdata[crs_pkg::PSW_W-1:0];
				default: d.cause = q.cause;
			endcase
		end
		// Flag updates follow the direct write so a new event wins
		if (flags_i.we)
		begin
			d.program_status_word[crs_pkg::PSW_Z] = flags_i.z;
			d.program_status_word[crs_pkg::PSW_S] = flags_i.s;
			d.program_status_word[crs_pkg::PSW_OV] = flags_i.ov;
			d.program_status_word[crs_pkg::PSW_CY] = flags_i.cy;
			if (flags_i.saturation_flag)
				d.program_status_word[crs_pkg::PSW_SAT] = 1'b1;
		end
		if (bit_req_i.go)
			d.program_status_word[crs_pkg::PSW_Z] = bit_zero;
		// Return restores from the pair that the active level used
		if (evt_i.reti)
		begin
			if (q.program_status_word[crs_pkg::PSW_NP])
			begin
				d.pc = q.nmi_pc[crs_pkg::PC_W-1:0];
				d.program_status_word = q.nmi_st[crs_pkg::PSW_W-1:0];
			end
			else
			begin
				d.pc = q.exc_pc[crs_pkg::PC_W-1:0];
				d.program_status_word = q.exc_st[crs_pkg::PSW_W-1:0];
			end
		end
		// NMI takes precedence over a coincident exception
		if (evt_i.nmi)
		begin
			d.nmi_pc = {8'h00, q.pc};
			d.nmi_st = {24'h000000, q.program_status_word};
			// Upper half takes the code, lower half untouched
			d.cause[crs_pkg::XLEN-1:crs_pkg::CAUSE_NMI_LSB] = evt_i.nmi_code;
			d.program_status_word[crs_pkg::PSW_NP] = 1'b1;
			d.program_status_word[crs_pkg::PSW_ID] = 1'b1;
		end
		else if (evt_i.exc)
		begin
			d.exc_pc = {8'h00, q.pc};
			d.exc_st = {24'h000000, q.program_status_word};
			d.cause[crs_pkg::CODE_W-1:0] = evt_i.exc_code;
			d.program_status_word[crs_pkg::PSW_EXC] = 1'b1;
			d.program_status_word[crs_pkg::PSW_ID] = 1'b1;
		end
		d.pc[0] = 1'b0;
		// Flags addresses beyond the 4 MB that is present
		d.pc_unimpl = |d.pc[crs_pkg::PC_W-1:crs_pkg::PHYS_W];
	end

	always_ff @(posedge clk_i or negedge nrst_i)
	begin
		if (!nrst_i)
			q <= ST_RST;
		else
			q <= d;
	end

	assign retire_o = q.pipe[crs_pkg::PIPE_STAGES-1];
	assign pc_o = {8'h00, q.pc};
	assign pc_unimpl_o = q.pc_unimpl;
	assign rd_a_o = q.rd_a;
	assign rd_b_o = q.rd_b;
	assign sh_res_o = q.sh_res;
	assign bit_res_o = q.bit_res;
	assign bit_zero_o = q.bit_zero;
	assign sr_rdata_o = q.sr_rdata;
	assign psw_o = {24'h000000, q.program_status_word};

	logic [crs_pkg::PC_W-1:0] pc_sum_chk;
	logic plain_exc;
	logic psw_wr;
	assign pc_sum_chk = (q.pc + pc_req_i.offset) & 24'hFFFFFE;
	assign plain_exc = evt_i.exc && !evt_i.nmi;
	assign psw_wr = sr_req_i.we && sr_req_i.idx == crs_pkg::SR_PSW;

	default clocking cb @(posedge clk_i);
	endclocking
	default disable iff (!nrst_i);

	sequence s_fill;
		issue_i;
	endsequence
	sequence s_drain;
		##5 retire_o;
	endsequence

	property p_retire;
		s_fill |-> s_drain;
	endproperty
	a_retire: assert property (p_retire)
		else $error("issued instruction did not retire after five clocks");

	property p_no_ghost;
		retire_o |-> $past(issue_i, 5);
	endproperty
	a_no_ghost: assert property (p_no_ghost)
		else $error("retire without an issue five clocks earlier");

	property p_pc_form;
		pc_req_i.load |=> pc_o[31:24] == 8'h00 && !pc_o[0];
	endproperty
	a_pc_form: assert property (p_pc_form)
		else $error("program counter upper bits or bit 0 not zero");

	property p_pc_wrap;
		pc_req_i.add && !pc_req_i.load && !evt_i.reti
			|=> pc_o[23:0] == $past(pc_sum_chk);
	endproperty
	a_pc_wrap: assert property (p_pc_wrap)
		else $error("program counter add did not wrap within 24 bits");
	property p_exc_save;
		plain_exc |=> q.exc_pc == {8'h00, $past(q.pc)}
			&& q.exc_st[7:0] == $past(q.program_status_word);
	endproperty
	a_exc_save: assert property (p_exc_save)
		else $error("exception did not save PC and status");
	property p_nmi_save;
		evt_i.nmi |=> q.nmi_pc[23:0] == $past(q.pc)
			&& q.nmi_st[7:0] == $past(q.program_status_word);
	endproperty
	a_nmi_save: assert property (p_nmi_save)
		else $error("NMI did not save PC and status");
	property p_cause_nmi;
		evt_i.nmi && !(sr_req_i.we && sr_req_i.idx == crs_pkg::SR_CAUSE)
			|=> q.cause == ({$past(evt_i.nmi_code), 16'h0000}
			| ($past(q.cause) & 32'h0000FFFF));
	endproperty
	a_cause_nmi: assert property (p_cause_nmi)
		else $error("NMI cause code not placed in upper half");
	property p_cause_exc;
		plain_exc |=> q.cause[15:0] == $past(evt_i.exc_code);
	endproperty
	a_cause_exc: assert property (p_cause_exc)
		else $error("exception cause code not placed in lower half");
	property p_sat_sticky;
		q.program_status_word[4] && !psw_wr && !evt_i.reti |=> q.program_status_word[4];
	endproperty
	a_sat_sticky: assert property (p_sat_sticky)
		else $error("saturation flag cleared without a status write");
	property p_ep_set;
		plain_exc |=> q.program_status_word[6] && psw_o[6];
	endproperty
	a_ep_set: assert property (p_ep_set)
		else $error("exception-active flag not set");
	property p_zero_reg;
		rd_a_idx_i == 5'h00 |=> rd_a_o == 32'h00000000;
	endproperty
	a_zero_reg: assert property (p_zero_reg)
		else $error("register zero read non-zero");
	property p_sr_reserved;
		sr_req_i.re && sr_req_i.idx > 5'h05 |=> sr_rdata_o == 32'h00000000;
	endproperty
	a_sr_reserved: assert property (p_sr_reserved)
		else $error("reserved system register read non-zero");
	property p_shift_left;
		sh_req_i.go && sh_req_i.op == crs_pkg::SH_LEFT
			|=> sh_res_o == $past(sh_req_i.data) << $past(sh_req_i.amt);
	endproperty
	a_shift_left: assert property (p_shift_left)
		else $error("left shift result wrong after one clock");
	property p_bit_set;
		bit_req_i.go && bit_req_i.op == crs_pkg::BIT_SET
			|=> bit_res_o == ($past(bit_req_i.octet)
			| (8'h01 << $past(bit_req_i.pos))) && psw_o[0] == bit_zero_o;
	endproperty
	a_bit_set: assert property (p_bit_set)
		else $error("bit set result or zero flag wrong");
endmodule : crs_regs

// File: bench/crs_pipe_model.sv
// Purpose: Pipeline-side partner that issues instructions, checks retires
// Assumes: Issue requests change just after a rising edge
// Notes: Compares per cycle at the falling edge, after outputs settle
module crs_pipe_model
(
	// Clock and reset
	input wire logic clk_i,
	input wire logic nrst_i,
	// Bench control
	input wire logic start_i,
	output int mism_o,
	// Design side
	input wire logic retire_i,
	output logic issue_o
);
	timeunit 1ns;
	timeprecision 1ns;
	logic [4:0] hist_q;
	assign issue_o = start_i;
	// Retire must appear exactly five cycles after its issue
	always @(negedge clk_i or negedge nrst_i)
	begin
		if (!nrst_i)
		begin
			hist_q <= 5'h00;
			mism_o <= 0;
		end
		else
		begin
			if (retire_i !== hist_q[4])
			begin
				mism_o <= mism_o + 1;
			end
			hist_q <= {hist_q[3:0], issue_o};
		end
	end
endmodule : crs_pipe_model

// File: bench/tb.sv
// Purpose: Self-checking bench of the CPU register set
// Assumes: Inputs change on rising edges, outputs read at falling edges
// Notes: Each scenario is one task
module tb;
	timeunit 1ns;
	timeprecision 1ns;
	logic clk_i = 1'b0;
	logic nrst_i;
	logic start;
	logic issue_i;
	logic retire_o;
	logic pc_unimpl_o;
	logic bit_zero_o;
	logic [4:0] rd_a_idx_i;
	logic [4:0] rd_b_idx_i;
	logic [7:0] bit_res_o;
	logic [31:0] pc_o, rd_a_o, rd_b_o, sh_res_o, sr_rdata_o, psw_o;
	crs_pkg::crs_pc_req_t pc_req_i;
	crs_pkg::crs_gpr_wr_t gpr_wr_i;
	crs_pkg::crs_sh_req_t sh_req_i;
	crs_pkg::crs_bit_req_t bit_req_i;
	crs_pkg::crs_sr_req_t sr_req_i;
	crs_pkg::crs_evt_t evt_i;
	crs_pkg::crs_flags_t flags_i;
	int pipe_bad;
	int fail_count = 0;
	int n_tests = 0;
	always #25 clk_i = ~clk_i;
	crs_regs crs_regs_inst (.clk_i(clk_i), .nrst_i(nrst_i),
		.issue_i(issue_i), .pc_req_i(pc_req_i), .retire_o(retire_o),
		.pc_o(pc_o), .pc_unimpl_o(pc_unimpl_o), .gpr_wr_i(gpr_wr_i),
		.rd_a_idx_i(rd_a_idx_i), .rd_b_idx_i(rd_b_idx_i),
		.rd_a_o(rd_a_o), .rd_b_o(rd_b_o), .sh_req_i(sh_req_i),
		.bit_req_i(bit_req_i), .sh_res_o(sh_res_o), .bit_res_o(bit_res_o),
		.bit_zero_o(bit_zero_o), .sr_req_i(sr_req_i), .evt_i(evt_i),
		.flags_i(flags_i), .sr_rdata_o(sr_rdata_o), .psw_o(psw_o));
	crs_pipe_model crs_pipe_model_inst (.clk_i(clk_i), .nrst_i(nrst_i),
		.start_i(start), .mism_o(pipe_bad), .retire_i(retire_o),
		.issue_o(issue_i));
	task chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
		n_tests++;
		if (got !== exp)
		begin
			fail_count++;
			$display("BAD %s expected %h seen %h", nm, exp, got);
		end
	endtask : chk
	task sr_op(input logic we, input logic [4:0] idx, input logic [31:0] wd);
		@(posedge clk_i);
		sr_req_i <= {we, ~we, idx, wd};
		@(posedge clk_i);
		sr_req_i <= '0;
		@(negedge clk_i);
	endtask : sr_op
	task sr_rd(input logic [4:0] idx, input logic [31:0] exp);
		sr_op(1'b0, idx, 32'h00000000);
		chk("sr_rdata_o", exp, sr_rdata_o);
	endtask : sr_rd
	task pc_do(input logic ad, input logic [23:0] v, input logic [31:0] exp);
		@(posedge clk_i);
		pc_req_i <= {ad, v, ~ad, v};
		@(posedge clk_i);
		pc_req_i <= '0;
		@(negedge clk_i);
		chk("pc_o", exp, pc_o);
		chk("pc_unimpl_o", {31'h0, exp[23:22] != 2'h0}, {31'h0, pc_unimpl_o});
	endtask : pc_do
	task evt(input crs_pkg::crs_evt_t e);
		@(posedge clk_i);
		evt_i <= e;
		@(posedge clk_i);
		evt_i <= '0;
		@(negedge clk_i);
	endtask : evt
	task sh(input crs_pkg::crs_shop_t op, input logic [31:0] d,
		input logic [4:0] a, input logic [31:0] exp);
		@(posedge clk_i);
		sh_req_i <= {1'b1, op, d, a};
		@(posedge clk_i);
		sh_req_i <= '0;
		@(negedge clk_i);
		chk("sh_res_o", exp, sh_res_o);
	endtask : sh
	task bt(input crs_pkg::crs_bitop_t op, input logic [2:0] p,
		input logic [7:0] exp, input logic z);
		@(posedge clk_i);
		bit_req_i <= {1'b1, op, 8'h0F, p};
		@(posedge clk_i);
		bit_req_i <= '0;
		@(negedge clk_i);
		chk("bit_res_o", {24'h0, exp}, {24'h0, bit_res_o});
		chk("bit_zero_o", {31'h0, z}, {31'h0, bit_zero_o});
		chk("psw_o zero flag", {31'h0, z}, {31'h0, psw_o[crs_pkg::PSW_Z]});
	endtask : bt
	task flg(input logic saturation_flag);
		@(posedge clk_i);
		flags_i <= {1'b1, 4'h0, saturation_flag};
		@(posedge clk_i);
		flags_i <= '0;
		@(negedge clk_i);
		chk("psw_o saturation", 32'h1, {31'h0, psw_o[crs_pkg::PSW_SAT]});
	endtask : flg
	task t_reset;
		chk("pc_o reset", 32'h00000000, pc_o);
		chk("psw_o reset", 32'h00000000, psw_o);
		for (int i = 0; i < 6; i++)
		begin
			sr_rd(i[4:0], 32'h00000000);
		end
		sr_op(1'b1, 5'h06, 32'h12345678);
		sr_rd(5'h06, 32'h00000000);
		sr_op(1'b1, 5'h04, 32'hA5A5C3C3);
		sr_rd(5'h04, 32'hA5A5C3C3);
	endtask : t_reset
	task t_pipe;
		@(posedge clk_i);
		start <= 1'b1;
		repeat (2) @(posedge clk_i);
		start <= 1'b0;
		@(posedge clk_i);
		start <= 1'b1;
		@(posedge clk_i);
		start <= 1'b0;
		repeat (8) @(negedge clk_i);
		chk("retire timing", 32'h0, pipe_bad);
	endtask : t_pipe
	task t_pc;
		pc_do(1'b0, 24'hFFFFFE, 32'h00FFFFFE);
		pc_do(1'b1, 24'h000003, 32'h00000000);
		pc_do(1'b0, 24'h400001, 32'h00400000);
		pc_do(1'b0, 24'h3FFFFE, 32'h003FFFFE);
	endtask : t_pc
	task t_gpr;
		@(posedge clk_i);
		gpr_wr_i <= {1'b1, 5'h07, 32'hDEADBEEF};
		@(posedge clk_i);
		gpr_wr_i <= {1'b1, 5'h00, 32'hFFFFFFFF};
		@(posedge clk_i);
		gpr_wr_i <= '0;
		rd_a_idx_i <= 5'h07;
		rd_b_idx_i <= 5'h00;
		@(posedge clk_i);
		@(negedge clk_i);
		chk("rd_a_o", 32'hDEADBEEF, rd_a_o);
		chk("rd_b_o", 32'h00000000, rd_b_o);
		@(posedge clk_i);
		rd_a_idx_i <= 5'h00;
		rd_b_idx_i <= 5'h07;
		@(posedge clk_i);
		@(negedge clk_i);
		chk("rd_a_o zero", 32'h00000000, rd_a_o);
		chk("rd_b_o r7", 32'hDEADBEEF, rd_b_o);
	endtask : t_gpr
	task t_alu;
		sh(crs_pkg::SH_LEFT, 32'h80000001, 5'h01, 32'h00000002);
		sh(crs_pkg::SH_RIGHT, 32'h80000000, 5'h1F, 32'h00000001);
		sh(crs_pkg::SH_ARITH, 32'h80000000, 5'h04, 32'hF8000000);
		bt(crs_pkg::BIT_SET, 3'h3, 8'h0F, 1'b0);
		bt(crs_pkg::BIT_CLR, 3'h3, 8'h07, 1'b0);
		bt(crs_pkg::BIT_NOT, 3'h3, 8'h07, 1'b0);
		bt(crs_pkg::BIT_TST, 3'h3, 8'h0F, 1'b0);
		bt(crs_pkg::BIT_SET, 3'h5, 8'h2F, 1'b1);
	endtask : t_alu
	task t_sat;
		flg(1'b1);
		flg(1'b0);
		sr_op(1'b1, 5'h05, 32'h00000000);
		chk("psw_o cleared", 32'h00000000, psw_o);
	endtask : t_sat
	task t_evt;
		pc_do(1'b0, 24'h000100, 32'h00000100);
		evt({1'b1, 16'h1234, 1'b0, 16'h0000, 1'b0});
		chk("psw_o after exception", 32'h00000060, psw_o);
		sr_rd(5'h00, 32'h00000100);
		sr_rd(5'h01, 32'h00000000);
		sr_rd(5'h04, 32'hA5A51234);
		evt({1'b0, 16'h0000, 1'b1, 16'hABCD, 1'b0});
		chk("psw_o nmi flag", 32'h1, {31'h0, psw_o[crs_pkg::PSW_NP]});
		sr_rd(5'h02, 32'h00000100);
		sr_rd(5'h03, 32'h00000060);
		sr_rd(5'h04, 32'hABCD1234);
		sr_rd(5'h00, 32'h00000100);
		pc_do(1'b0, 24'h000200, 32'h00000200);
		evt({1'b0, 16'h0000, 1'b0, 16'h0000, 1'b1});
		chk("pc_o restored", 32'h00000100, pc_o);
	endtask : t_evt
	task close_out;
		$display("comparisons %0d mismatches %0d", n_tests, fail_count);
		if (fail_count == 0 && n_tests > 0)
		begin
			$display("Regression OK");
		end
		else
		begin
			$display("Regression broken");
		end
		$finish;
	endtask : close_out
	initial
	begin
		nrst_i = 1'b0;
		start = 1'b0;
		rd_a_idx_i = 5'h00;
		rd_b_idx_i = 5'h00;
		pc_req_i = '0;
		gpr_wr_i = '0;
		sh_req_i = '0;
		bit_req_i = '0;
		sr_req_i = '0;
		evt_i = '0;
		flags_i = '0;
		repeat (8) @(posedge clk_i);
		nrst_i <= 1'b1;
		@(negedge clk_i);
		t_reset();
		t_pipe();
		t_pc();
		t_gpr();
		t_alu();
		t_sat();
		t_evt();
		close_out();
	end
endmodule : tb
